// [logic/pdc_top.sv]
// Top of the emulated port groups, capture bank, event counter and cascaded timer
`timescale 1ns/1ps
module pdc_top
   import pdc_pkg::*;
#(
   parameter int GROUP_COUNT = 4,
   parameter bit CAPTURE_BANK = 1'b0
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [7:0] IO_ADDR,
   input wire logic IO_WR,
   input wire logic IO_RD,
   input wire logic [7:0] IO_WDATA,
   output logic [7:0] IO_RDATA,
   input wire logic [pdc_pkg::GROUP_MAX*pdc_pkg::GROUP_LINES-1:0] DIO_IN,
   output logic [pdc_pkg::GROUP_MAX*pdc_pkg::GROUP_LINES-1:0] DIO_OUT,
   output logic [pdc_pkg::GROUP_MAX*pdc_pkg::GROUP_LINES-1:0] DIO_OE,
   input wire logic CAPTURE_STROBE,
   input wire logic EVENT_EDGE_RISING,
   output logic [3:0] INT_SOURCE,
   output logic EVENT_IRQ,
   output logic TIMER_IRQ
);
   import pdc_pkg::*;

   typedef struct packed {
      logic [7:0] rdata;
      logic [47:0] capture;
      logic strobe_q;
      logic event_in_q;
      logic [7:0] accum;
      logic tick_2m;
      logic timer_lo_q;
      logic [3:0] int_src;
      logic event_irq;
      logic timer_irq;
   } pdc_top_t;
   pdc_top_t s_r, s_nxt;

   logic [7:0] g_rdata [GROUP_MAX];
   logic [23:0] g_view [GROUP_MAX];
   logic [7:0] c_rdata [3];
   logic [2:0] c_out;
   logic [2:0] c_tick;
   logic [2:0] c_wr_mode;
   logic [2:0] c_wr_count;
   logic [2:0] c_rd;
   logic [1:0] gsel;
   logic is_group;
   logic is_capture;
   logic is_counter;
   logic event_edge;
   logic [7:0] accum_sum;

   function automatic logic edge_seen(input logic prev, input logic cur, input logic rising);
      edge_seen = rising ? (~prev & cur) : (prev & ~cur);
   endfunction

   assign gsel = IO_ADDR[3:2];
   assign is_group = (IO_ADDR[7:4] == 4'h0) && (32'(gsel) < GROUP_COUNT);
   assign is_capture = CAPTURE_BANK && (IO_ADDR[7:4] == 4'h0) && (IO_ADDR[3:2] >= 2'h2)
                       && (IO_ADDR[1:0] != 2'h3);
   assign is_counter = (IO_ADDR[7:2] == OFS_COUNTER0[7:2]);

   genvar gi;
   generate
      for (gi = 0; gi < GROUP_MAX; gi++) begin : g_grp
         if (gi < GROUP_COUNT) begin : g_on
            pdc_group u_group (
               .clk(CORE_CLK),
               .rst(RST),
               .wr_en(IO_WR && is_group && !is_capture && gsel == 2'(gi)),
               .sel(IO_ADDR[1:0]),
               .wdata(IO_WDATA),
               .pin_in(DIO_IN[gi*GROUP_LINES +: GROUP_LINES]),
               .pin_out(DIO_OUT[gi*GROUP_LINES +: GROUP_LINES]),
               .pin_oe(DIO_OE[gi*GROUP_LINES +: GROUP_LINES]),
               .port_view(g_view[gi]),
               .rdata(g_rdata[gi])
            );
         end else begin : g_off
            assign DIO_OUT[gi*GROUP_LINES +: GROUP_LINES] = 24'h000000;
            assign DIO_OE[gi*GROUP_LINES +: GROUP_LINES] = 24'h000000;
            assign g_view[gi] = 24'h000000;
            assign g_rdata[gi] = 8'h00;
         end
      end
   endgenerate

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         c_wr_count[i] = IO_WR && is_counter && (IO_ADDR[1:0] == 2'(i));
         c_rd[i] = IO_RD && is_counter && (IO_ADDR[1:0] == 2'(i));
         c_wr_mode[i] = IO_WR && (IO_ADDR == OFS_COUNTER_MODE)
                        && (IO_WDATA[MODE_SEL_LSB +: 2] == 2'(i));
      end
   end

   assign event_edge = edge_seen(s_r.event_in_q, g_view[0][16 + EVENT_COUNT_INPUT_BIT],
                                 EVENT_EDGE_RISING);
   assign c_tick[0] = event_edge;
   assign c_tick[1] = s_r.tick_2m;
   assign c_tick[2] = s_r.timer_lo_q & ~c_out[1];

   genvar ci;
   generate
      for (ci = 0; ci < 3; ci++) begin : g_cnt
         pdc_counter u_counter (
            .clk(CORE_CLK),
            .rst(RST),
            .tick(c_tick[ci]),
            .wr_mode(c_wr_mode[ci]),
            .wr_count(c_wr_count[ci]),
            .rd_count(c_rd[ci]),
            .wdata(IO_WDATA),
            .rdata(c_rdata[ci]),
            .out(c_out[ci])
         );
      end
   endgenerate

   assign accum_sum = s_r.accum + TICK_STEP;

   always_comb begin
      s_nxt = s_r;
      s_nxt.strobe_q = CAPTURE_STROBE;
      s_nxt.event_in_q = g_view[0][16 + EVENT_COUNT_INPUT_BIT];
      s_nxt.timer_lo_q = c_out[1];
      if (accum_sum >= TICK_MODULUS) begin
         s_nxt.accum = accum_sum - TICK_MODULUS;
         s_nxt.tick_2m = 1'b1;
      end else begin
         s_nxt.accum = accum_sum;
         s_nxt.tick_2m = 1'b0;
      end
      if (CAPTURE_BANK && edge_seen(s_r.strobe_q, CAPTURE_STROBE, 1'b1)) begin
         s_nxt.capture = {g_view[1], g_view[0]};
      end
      s_nxt.int_src = {g_view[1][16 + THIRD_IRQ_BIT_THREE], g_view[1][16 + THIRD_IRQ_BIT_ZERO],
                       g_view[0][16 + THIRD_IRQ_BIT_THREE], g_view[0][16 + THIRD_IRQ_BIT_ZERO]};
      s_nxt.event_irq = c_out[0];
      s_nxt.timer_irq = c_out[2];
      if (IO_RD) begin
         if (is_capture) begin
            s_nxt.rdata = s_r.capture[(24 * 32'(IO_ADDR[2])) + 8 * 32'(IO_ADDR[1:0]) +: 8];
         end else if (is_group) begin
            s_nxt.rdata = g_rdata[gsel];
         end else if (is_counter && IO_ADDR[1:0] != 2'h3) begin
            s_nxt.rdata = c_rdata[IO_ADDR[1:0]];
         end else begin
            s_nxt.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         s_r.rdata <= 8'h00;
         s_r.capture <= 48'h000000000000;
         s_r.strobe_q <= 1'b0;
         s_r.event_in_q <= 1'b0;
         s_r.accum <= 8'h00;
         s_r.tick_2m <= 1'b0;
         s_r.timer_lo_q <= 1'b0;
         s_r.int_src <= 4'h0;
         s_r.event_irq <= 1'b0;
         s_r.timer_irq <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign IO_RDATA = s_r.rdata;
   assign INT_SOURCE = s_r.int_src;
   assign EVENT_IRQ = s_r.event_irq;
   assign TIMER_IRQ = s_r.timer_irq;
endmodule

// [logic/pdc_pkg.sv]
// Constants, types and address map of the emulated port-group and counter block
package pdc_pkg;
   localparam int GROUP_MAX = 4;
   localparam int GROUP_LINES = 24;
   localparam int BYTE_W = 8;
   localparam logic [7:0] OFS_FIRST = 8'h00;
   localparam logic [7:0] OFS_SECOND = 8'h01;
   localparam logic [7:0] OFS_THIRD = 8'h02;
   localparam logic [7:0] OFS_DIRECTION = 8'h03;
   localparam logic [7:0] OFS_GROUP_STRIDE = 8'h04;
   localparam logic [7:0] OFS_CAPTURE_LO = 8'h08;
   localparam logic [7:0] OFS_CAPTURE_HI = 8'h0C;
   localparam logic [7:0] OFS_COUNTER0 = 8'h10;
   localparam logic [7:0] OFS_COUNTER_MODE = 8'h13;
   localparam logic [7:0] DIRECTION_RESET = 8'h1B;
   localparam int DIR_FIRST_BIT = 4;
   localparam int DIR_THIRD_UPPER_BIT = 3;
   localparam int DIR_SECOND_BIT = 1;
   localparam int DIR_THIRD_LOWER_BIT = 0;
   localparam int THIRD_IRQ_BIT_ZERO = 0;
   localparam int THIRD_IRQ_BIT_THREE = 3;
   localparam int EVENT_COUNT_INPUT_BIT = 4;
   localparam int MODE_SEL_LSB = 6;
   localparam int MODE_FIELD_LSB = 1;
   localparam logic [1:0] COUNTER_READBACK = 2'h3;
   localparam int CORE_CLK_KHZ = 125000;
   localparam int TIMER_CLK_KHZ = 2000;
   localparam int TICK_GCD = 1000;
   localparam logic [7:0] TICK_STEP = 8'(TIMER_CLK_KHZ / TICK_GCD);
   localparam logic [7:0] TICK_MODULUS = 8'(CORE_CLK_KHZ / TICK_GCD);
   typedef enum logic [2:0] {
      PDC_TERMINAL_COUNT,
      PDC_ONE_SHOT,
      PDC_RATE_GEN,
      PDC_SQUARE_WAVE,
      PDC_SW_STROBE,
      PDC_HW_STROBE
   } pdc_mode_t;
endpackage

// [logic/pdc_group.sv]
// One emulated port group: three data latches, direction word and read view
`timescale 1ns/1ps
module pdc_group
   import pdc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [1:0] sel,
   input wire logic [7:0] wdata,
   input wire logic [23:0] pin_in,
   output logic [23:0] pin_out,
   output logic [23:0] pin_oe,
   output logic [23:0] port_view,
   output logic [7:0] rdata
);
   typedef struct packed {
      logic [7:0] dir;
      logic [23:0] latch;
      logic [23:0] oe;
   } pdc_grp_t;
   pdc_grp_t s_r, s_nxt;
   logic [7:0] word;

   function automatic logic [23:0] oe_of(input logic [7:0] d);
      oe_of = {{4{~d[DIR_THIRD_UPPER_BIT]}}, {4{~d[DIR_THIRD_LOWER_BIT]}},
               {8{~d[DIR_SECOND_BIT]}}, {8{~d[DIR_FIRST_BIT]}}};
   endfunction

   always_comb begin
      s_nxt = s_r;
      word = oe_of(s_r.dir) == 24'h0 ? 8'h00 : 8'h00;
      if (wr_en) begin
         case (sel)
            2'h0: s_nxt.latch[7:0] = wdata;
            2'h1: s_nxt.latch[15:8] = wdata;
            2'h2: s_nxt.latch[23:16] = wdata;
            default: s_nxt.dir = wdata;
         endcase
      end
      s_nxt.oe = oe_of(s_nxt.dir);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r.dir <= DIRECTION_RESET;
         s_r.latch <= 24'h000000;
         s_r.oe <= 24'h000000;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pin_out = s_r.latch;
   assign pin_oe = s_r.oe;
   assign port_view = (s_r.oe & s_r.latch) | (~s_r.oe & pin_in);
   always_comb begin
      case (sel)
         2'h0: rdata = port_view[7:0];
         2'h1: rdata = port_view[15:8];
         2'h2: rdata = port_view[23:16];
         default: rdata = word;
      endcase
   end
endmodule

// [logic/pdc_counter.sv]
// One 16-bit down counter with byte load and byte read, terminal-count and rate modes
`timescale 1ns/1ps
module pdc_counter
   import pdc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic wr_mode,
   input wire logic wr_count,
   input wire logic rd_count,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic out
);
   typedef struct packed {
      pdc_mode_t mode;
      logic [15:0] reload;
      logic [15:0] count;
      logic load_msb;
      logic read_msb;
      logic running;
      logic out;
   } pdc_cnt_t;
   pdc_cnt_t s_r, s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (wr_mode) begin
         s_nxt.mode = pdc_mode_t'(wdata[MODE_FIELD_LSB +: 3]);
         s_nxt.load_msb = 1'b0;
         s_nxt.read_msb = 1'b0;
         s_nxt.running = 1'b0;
         s_nxt.out = (s_nxt.mode != PDC_TERMINAL_COUNT);
      end else if (wr_count) begin
         if (s_r.load_msb) begin
            s_nxt.reload[15:8] = wdata;
            s_nxt.count = {wdata, s_r.reload[7:0]};
            s_nxt.running = 1'b1;
            s_nxt.out = (s_r.mode != PDC_TERMINAL_COUNT);
         end else begin
            s_nxt.reload[7:0] = wdata;
         end
         s_nxt.load_msb = ~s_r.load_msb;
      end else if (tick && s_r.running) begin
         case (s_r.mode)
            PDC_RATE_GEN: begin
               s_nxt.out = (s_r.count != 16'h0002);
               s_nxt.count = (s_r.count == 16'h0001) ? s_r.reload : s_r.count - 16'h0001;
            end
            default: begin
               s_nxt.count = s_r.count - 16'h0001;
               if (s_r.count == 16'h0001) begin
                  s_nxt.out = 1'b1;
               end
            end
         endcase
      end
      if (rd_count) begin
         s_nxt.read_msb = ~s_r.read_msb;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r.mode <= PDC_TERMINAL_COUNT;
         s_r.reload <= 16'h0000;
         s_r.count <= 16'h0000;
         s_r.load_msb <= 1'b0;
         s_r.read_msb <= 1'b0;
         s_r.running <= 1'b0;
         s_r.out <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata = s_r.read_msb ? s_r.count[15:8] : s_r.count[7:0];
   assign out = s_r.out;
endmodule

// [test/pdc_top_properties.sv]
// Concurrent checks on the port-group block top ports
`timescale 1ns/1ps
module pdc_top_properties
   import pdc_pkg::*;
#(
   parameter int GROUP_COUNT = 4,
   parameter bit CAPTURE_BANK = 1'b0
) (
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic [7:0] IO_ADDR,
   input wire logic IO_WR,
   input wire logic IO_RD,
   input wire logic [7:0] IO_WDATA,
   input wire logic [7:0] IO_RDATA,
   input wire logic [pdc_pkg::GROUP_MAX*pdc_pkg::GROUP_LINES-1:0] DIO_IN,
   input wire logic [pdc_pkg::GROUP_MAX*pdc_pkg::GROUP_LINES-1:0] DIO_OUT,
   input wire logic [pdc_pkg::GROUP_MAX*pdc_pkg::GROUP_LINES-1:0] DIO_OE,
   input wire logic [3:0] INT_SOURCE,
   input wire logic EVENT_IRQ,
   input wire logic TIMER_IRQ
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   wire dir_wr = IO_WR && IO_ADDR == 8'h03;
   a_reset_all_input: assert property ($fell(RST) |-> DIO_OE == '0 && DIO_OUT == '0 && INT_SOURCE == 4'h0)
      else $error("outputs not cleared by reset");
   a_dir_whole_ports: assert property (dir_wr |=> DIO_OE[7:0] == {8{~$past(IO_WDATA[4])}}
      && DIO_OE[15:8] == {8{~$past(IO_WDATA[1])}}) else $error("whole-port direction wrong");
   a_dir_third_halves: assert property (dir_wr |=> DIO_OE[23:20] == {4{~$past(IO_WDATA[3])}}
      && DIO_OE[19:16] == {4{~$past(IO_WDATA[0])}}) else $error("third-port half direction wrong");
   a_oe_hold_idle: assert property (!IO_WR |=> $stable(DIO_OE))
      else $error("direction changed without a write");
   a_latch_takes_data: assert property (IO_WR && IO_ADDR == 8'h00 |=> DIO_OUT[7:0] == $past(IO_WDATA))
      else $error("first port latch not updated");
   a_read_live_pin: assert property (IO_RD && IO_ADDR == 8'h01 && DIO_OE[15:8] == 8'h00
      |=> IO_RDATA == $past(DIO_IN[15:8])) else $error("input read not live pin level");
   a_read_out_latch: assert property (IO_RD && IO_ADDR == 8'h02 && DIO_OE[23:16] == 8'hFF
      |=> IO_RDATA == $past(DIO_OUT[23:16])) else $error("output read not latch value");
   a_ctrl_reads_zero: assert property (IO_RD && IO_ADDR == 8'h03 |=> IO_RDATA == 8'h00)
      else $error("direction word readable");
   a_mode_clears_event: assert property (IO_WR && IO_ADDR == 8'h13 && IO_WDATA == 8'h30 |-> ##2 !EVENT_IRQ)
      else $error("event output not cleared by mode write");
   a_irq_src_view: assert property ($stable(DIO_IN) && DIO_OE[19:16] == 4'h0 && DIO_OE[43:40] == 4'h0
      |=> INT_SOURCE == {$past(DIO_IN[43]), $past(DIO_IN[40]), $past(DIO_IN[19]), $past(DIO_IN[16])})
      else $error("interrupt sources wrong");
   c_all_output: cover property (dir_wr && IO_WDATA == 8'h00);
   c_event_irq: cover property ($rose(EVENT_IRQ));
   c_timer_irq: cover property ($fell(TIMER_IRQ));
endmodule

bind pdc_top pdc_top_properties #(.GROUP_COUNT(GROUP_COUNT), .CAPTURE_BANK(CAPTURE_BANK)) i_pdc_top_properties (
   .CORE_CLK(CORE_CLK), .RST(RST), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_WDATA(IO_WDATA),
   .IO_RDATA(IO_RDATA), .DIO_IN(DIO_IN), .DIO_OUT(DIO_OUT), .DIO_OE(DIO_OE), .INT_SOURCE(INT_SOURCE),
   .EVENT_IRQ(EVENT_IRQ), .TIMER_IRQ(TIMER_IRQ));

// [test/pdc_host.sv]
// Host model issuing byte I/O cycles on the register bus
`timescale 1ns/1ps
module pdc_host (
   input wire logic clk,
   output logic [7:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata,
   input wire logic [7:0] io_rdata
);
   initial begin
      io_addr = 8'h00;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   // Single byte write; released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
      io_addr = ~a;
      io_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      io_addr = ~a;
      d = io_rdata;
   endtask
endmodule

// [test/pdc_top_tb.sv]
// Self-checking bench for the port-group block
`timescale 1ns/1ps
module pdc_top_tb;
   import pdc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [95:0] dio_in = 96'h0000_0000_0000_0000_005A_C3E1;
   logic edge_rise = 1'b1;
   logic strobe = 1'b0;
   wire [7:0] rdata_cap;
   logic [95:0] dio_oe_cap;
   wire [7:0] addr;
   wire [7:0] wdata;
   wire [7:0] rdata;
   wire wr;
   wire rd;
   logic [95:0] dio_out;
   logic [95:0] dio_oe;
   logic [3:0] int_src;
   logic ev_irq;
   logic tm_irq;
   int errors = 0;
   int comparisons = 0;
   logic [7:0] lat [3] = '{8'hA5, 8'h3C, 8'h96};
   // Direction word beside the enables it should give
   logic [31:0] rows [16] = '{32'h00FFFFFF, 32'h01F0FFFF, 32'h02FF00FF, 32'h03F000FF, 32'h080FFFFF, 32'h0900FFFF,
      32'h0A0F00FF, 32'h0B0000FF, 32'h10FFFF00, 32'h11F0FF00, 32'h12FF0000, 32'h13F00000, 32'h180FFF00,
      32'h1900FF00, 32'h1A0F0000, 32'h1B000000};
   logic [7:0] d;
   int c;

   always #4 clk = ~clk;

   pdc_top #(.GROUP_COUNT(4), .CAPTURE_BANK(1'b0)) i_pdc_top (
      .CORE_CLK(clk), .RST(rst), .IO_ADDR(addr), .IO_WR(wr), .IO_RD(rd), .IO_WDATA(wdata), .IO_RDATA(rdata),
      .DIO_IN(dio_in), .DIO_OUT(dio_out), .DIO_OE(dio_oe), .CAPTURE_STROBE(strobe), .EVENT_EDGE_RISING(edge_rise),
      .INT_SOURCE(int_src), .EVENT_IRQ(ev_irq), .TIMER_IRQ(tm_irq));
   // Two-group capture variant on the same bus
   pdc_top #(.GROUP_COUNT(2), .CAPTURE_BANK(1'b1)) i_pdc_top_cap (
      .CORE_CLK(clk), .RST(rst), .IO_ADDR(addr), .IO_WR(wr), .IO_RD(rd), .IO_WDATA(wdata), .IO_RDATA(rdata_cap),
      .DIO_IN(dio_in), .DIO_OUT(), .DIO_OE(dio_oe_cap), .CAPTURE_STROBE(strobe), .EVENT_EDGE_RISING(edge_rise),
      .INT_SOURCE(), .EVENT_IRQ(), .TIMER_IRQ());
   pdc_host i_pdc_host (.clk(clk), .io_addr(addr), .io_wr(wr), .io_rd(rd), .io_wdata(wdata), .io_rdata(rdata));

   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_cnt(input string n, input int e, input int g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %0d seen %0d", n, e, g);
      end
   endtask
   // Cycles until the next falling edge of the timer output
   task automatic fall_gap(output int n);
      logic p;
      n = 0;
      p = 1'b0;
      while (n < 2000) begin
         @(negedge clk);
         n++;
         if (p === 1'b1 && tm_irq === 1'b0) break;
         p = tm_irq;
      end
   endtask
   task automatic final_report;
      $display("Counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      final_report();
   end

   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      chk("oe", 24'h0, dio_oe[23:0]);
      chk("out", 24'h0, dio_out[23:0]);
      i_pdc_host.rd(8'h03, d);
      chk("dir rd", 24'h0, 24'(d));
      i_pdc_host.rd(8'h20, d);
      chk("unmapped", 24'h0, 24'(d));
      for (int p = 0; p < 3; p++) i_pdc_host.wr(8'(p), lat[p]);
      chk("oe", 24'h0, dio_oe[23:0]);
      chk("out", {lat[2], lat[1], lat[0]}, dio_out[23:0]);
      i_pdc_host.rd(8'h01, d);
      chk("live", 24'hC3, 24'(d));
      dio_in[15:8] = 8'h4B;
      i_pdc_host.rd(8'h01, d);
      chk("live", 24'h4B, 24'(d));
      for (int i = 0; i < 16; i++) begin
         i_pdc_host.wr(8'h03, rows[i][31:24]);
         chk("oe", rows[i][23:0], dio_oe[23:0]);
         chk("out", {lat[2], lat[1], lat[0]}, dio_out[23:0]);
         i_pdc_host.rd(8'h02, d);
         chk("third", 24'((lat[2] & rows[i][23:16]) | (dio_in[23:16] & ~rows[i][23:16])), 24'(d));
      end
      i_pdc_host.wr(8'h0F, 8'h00);
      chk("oe g4", 24'hFFFFFF, dio_oe[95:72]);
      chk("oe g1", 24'h0, dio_oe[23:0]);
      chk("oe absent", 24'h0, dio_oe_cap[95:72]);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      chk("oe g4", 24'h0, dio_oe[95:72]);
      dio_in[43:40] = 4'h8;
      dio_in[19:16] = 4'h1;
      repeat (3) @(negedge clk);
      chk("int src", 24'h9, 24'(int_src));
      // Capture on strobe rise, then move the pins away
      dio_in[47:0] = 48'h6655_4433_2211;
      strobe = 1'b1;
      @(negedge clk);
      dio_in[47:0] = 48'h0;
      strobe = 1'b0;
      for (int k = 0; k < 6; k++) begin
         i_pdc_host.rd(8'h08 + 8'(k + k / 3), d);
         chk("capture", 24'(8'h11 * 8'(k + 1)), 24'(rdata_cap));
      end
      for (int e = 1; e >= 0; e--) begin
         edge_rise = e[0];
         dio_in[20] = ~e[0];
         i_pdc_host.wr(8'h13, 8'h30);
         i_pdc_host.wr(8'h10, 8'h02);
         i_pdc_host.wr(8'h10, 8'h00);
         for (int p = 0; p < 2; p++) begin
            chk("event", 24'h0, 24'(ev_irq));
            repeat (2) @(negedge clk);
            dio_in[20] = e[0];
            repeat (2) @(negedge clk);
            dio_in[20] = ~e[0];
         end
         repeat (3) @(negedge clk);
         chk("event", 24'h1, 24'(ev_irq));
      end
      i_pdc_host.wr(8'h13, 8'h30);
      i_pdc_host.wr(8'h10, 8'h34);
      i_pdc_host.wr(8'h10, 8'h12);
      i_pdc_host.rd(8'h10, d);
      chk("count lsb", 24'h34, 24'(d));
      i_pdc_host.rd(8'h10, d);
      chk("count msb", 24'h12, 24'(d));
      i_pdc_host.wr(8'h13, 8'h74);
      i_pdc_host.wr(8'h11, 8'h02);
      i_pdc_host.wr(8'h11, 8'h00);
      i_pdc_host.wr(8'h13, 8'hB4);
      i_pdc_host.wr(8'h12, 8'h02);
      i_pdc_host.wr(8'h12, 8'h00);
      fall_gap(c);
      fall_gap(c);
      chk_cnt("timer gap", 4 * CORE_CLK_KHZ / TIMER_CLK_KHZ, c);
      final_report();
   end
endmodule
